/* File: hrs_regs.svh */
// Summary of operation
// [R1] A 3-bit pointer selects the active entry; entries hold 10-bit PCs.
// [R2] Exactly four entries store saved program counter values.
// [R3] Push decrements the pointer, pop increments it.
// [R4] Subroutine call and interrupt entry both push the current PC.
// [R5] Last in, first out: pop returns the newest unpopped value.
// [R6] 111 empty, 110..011 hold entries 0..3, 010 means overflow.
// [R7] Interrupt return and call return both pop their saved address.
// [R8] Pop hands the top entry to the PC, pointer then marks the new top entry.
// [R9] Entry high byte holds PC bits 9:8, low byte bits 7:0; reset zero.
// [R10] Pointer register at 0xdf, entry bytes within 0xf0 to 0xff.
// [R11] Pointer register bit 7 is global interrupt enable, reset 0.
// [R12] Firmware should write 0x07 to the pointer register at start.
// [R13] Push past four levels moves the pointer but stores nothing.
`ifndef HRS_REGS_SVH
`define HRS_REGS_SVH

`define HRS_PC_W            10
`define HRS_PTR_W           3
`define HRS_DEPTH           4
`define HRS_BYTE_W          8
`define HRS_ADDR_PTR        8'hdf
`define HRS_ADDR_ENTRY_BASE 8'hf0
`define HRS_ADDR_ENTRY_LAST 8'hff
`define HRS_ADDR_STATUS     8'he0
`define HRS_ADDR_CLEAR      8'he1
`define HRS_ADDR_ENABLE     8'he2
`define HRS_PTR_EMPTY       3'h7
`define HRS_PTR_TOP         3'h6
`define HRS_PTR_OVER        3'h2
`define HRS_PTR_STEP        3'h1
`define HRS_IRQ_EN_BIT      7
`define HRS_IRQ_EN_RESET    1'b0
`define HRS_EV_W            4
`define HRS_EV_PUSH         0
`define HRS_EV_POP          1
`define HRS_EV_OVER         2
`define HRS_EV_UNDER        3
`define HRS_EV_RESET        4'h0

`endif

/* File: hrs_pkg.sv */
`include "hrs_regs.svh"
package hrs_pkg;

  typedef enum logic
  {
    HRS_RETURN_CALL,
    HRS_RETURN_IRQ
  } hrs_return_kind_type;

  typedef struct packed
  {
    logic                   wr;
    logic                   rd;
    logic [`HRS_BYTE_W-1:0] addr;
    logic [`HRS_BYTE_W-1:0] wdata;
  } hrs_bus_req_type;

  typedef struct packed
  {
    logic                 push;
    logic                 pop;
    hrs_return_kind_type  pop_kind;
    logic [`HRS_PC_W-1:0] pc;
  } hrs_core_req_type;

  typedef struct packed
  {
    logic                 valid;
    hrs_return_kind_type  kind;
    logic [`HRS_PC_W-1:0] pc;
  } hrs_pop_rsp_type;

endpackage

/* File: hrs_entry_file.sv */
`timescale 1ns/1ps
`include "hrs_regs.svh"
module hrs_entry_file
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH,
  parameter int PC_W  = `HRS_PC_W
)
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   core_wr,
  input  wire logic [`HRS_PTR_W-1:0]  core_idx,
  input  wire logic [PC_W-1:0]        core_data,
  input  wire logic                   sw_wr_lo,
  input  wire logic                   sw_wr_hi,
  input  wire logic [`HRS_PTR_W-1:0]  sw_idx,
  input  wire logic [`HRS_BYTE_W-1:0] sw_data,
  input  wire logic [`HRS_PTR_W-1:0]  rd_idx_a,
  output logic      [PC_W-1:0]        rd_data_a,
  input  wire logic [`HRS_PTR_W-1:0]  rd_idx_b,
  output logic      [PC_W-1:0]        rd_data_b
);

  logic [PC_W-1:0] mem_q [DEPTH];
  logic [PC_W-1:0] mem_d [DEPTH];

  function automatic logic hit(input logic [`HRS_PTR_W-1:0] idx);
    hit = 32'(idx) < DEPTH;
  endfunction

  always_comb
  begin
    mem_d = mem_q;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (sw_wr_lo && 32'(sw_idx) == i)
        mem_d[i][`HRS_BYTE_W-1:0] = sw_data; // [R9]
      if (sw_wr_hi && 32'(sw_idx) == i)
        mem_d[i][PC_W-1:`HRS_BYTE_W] = sw_data[PC_W-`HRS_BYTE_W-1:0]; // [R9]
      if (core_wr && 32'(core_idx) == i)
        mem_d[i] = core_data; // [R4]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mem_q <= '{default: '0}; // [R9]
    else
      mem_q <= mem_d;
  end

  always_comb
  begin
    rd_data_a = '0;
    rd_data_b = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (hit(rd_idx_a) && 32'(rd_idx_a) == i)
        rd_data_a = mem_q[i];
      if (hit(rd_idx_b) && 32'(rd_idx_b) == i)
        rd_data_b = mem_q[i];
    end
  end

endmodule

/* File: hrs_return_stack.sv */
`timescale 1ns/1ps
`include "hrs_regs.svh"
module hrs_return_stack
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH,
  parameter int PC_W  = `HRS_PC_W
)
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire hrs_bus_req_type        bus_req,
  output logic      [`HRS_BYTE_W-1:0] bus_rdata,
  input  wire hrs_core_req_type       core_req,
  output hrs_pop_rsp_type             pop_rsp,
  output logic                        global_irq_enable,
  output logic                        irq
);

  if (DEPTH < 1 || DEPTH > 6)
    $error("Depth must lie between one and six");
  if (PC_W <= `HRS_BYTE_W || PC_W > 2 * `HRS_BYTE_W)
    $error("PC width must fit two bytes");
  if (PC_W != `HRS_PC_W)
    $error("PC width must match the core request type");

  // Entry number held at a pointer value
  function automatic logic [`HRS_PTR_W-1:0] entry_of(
    input logic [`HRS_PTR_W-1:0] ptr);
    entry_of = `HRS_PTR_TOP - ptr; // [R6]
  endfunction

  // Pointer value that names a stored entry
  function automatic logic holds_entry(input logic [`HRS_PTR_W-1:0] ptr);
    holds_entry = ptr <= `HRS_PTR_TOP &&
                  32'(entry_of(ptr)) < DEPTH; // [R2] [R6]
  endfunction

  logic [`HRS_PTR_W-1:0]  ptr_q;
  logic [`HRS_PTR_W-1:0]  ptr_d;
  logic                   irq_en_q;
  logic                   irq_en_d;
  logic [`HRS_EV_W-1:0]   status_q;
  logic [`HRS_EV_W-1:0]   status_d;
  logic [`HRS_EV_W-1:0]   enable_q;
  logic [`HRS_EV_W-1:0]   enable_d;
  logic [`HRS_EV_W-1:0]   event_set;
  logic [`HRS_EV_W-1:0]   event_clr;
  logic [`HRS_BYTE_W-1:0] rdata_q;
  logic [`HRS_BYTE_W-1:0] rdata_d;
  hrs_pop_rsp_type        pop_q;
  hrs_pop_rsp_type        pop_d;

  logic                   do_push;
  logic                   do_pop;
  logic [`HRS_PTR_W-1:0]  push_ptr;
  logic                   push_fits;
  logic                   pop_fits;
  logic [`HRS_PTR_W-1:0]  push_idx;
  logic [`HRS_PTR_W-1:0]  pop_idx;
  logic [PC_W-1:0]        pop_data;

  logic                   in_entry;
  logic [`HRS_BYTE_W-1:0] entry_off;
  logic [`HRS_PTR_W-1:0]  sw_idx;
  logic                   sw_hi;
  logic                   sw_wr_lo;
  logic                   sw_wr_hi;
  logic [PC_W-1:0]        sw_rd_data;
  logic [`HRS_BYTE_W-1:0] sw_rd_byte;

  // Core sequencer requests; a push in the same cycle wins over a pop
  always_comb
  begin
    do_push   = core_req.push; // [R4]
    do_pop    = core_req.pop && !core_req.push; // [R7]
    push_ptr  = ptr_q - `HRS_PTR_STEP; // [R3]
    push_fits = holds_entry(push_ptr); // [R13]
    pop_fits  = holds_entry(ptr_q); // [R5]
    push_idx  = entry_of(push_ptr); // [R6]
    pop_idx   = entry_of(ptr_q); // [R8]
  end

  // Register bus decode for the entry bytes
  always_comb
  begin
    in_entry  = bus_req.addr >= `HRS_ADDR_ENTRY_BASE &&
                bus_req.addr <= `HRS_ADDR_ENTRY_LAST; // [R10]
    entry_off = bus_req.addr - `HRS_ADDR_ENTRY_BASE;
    sw_idx    = entry_off[`HRS_PTR_W:1];
    sw_hi     = entry_off[0];
    sw_wr_lo  = bus_req.wr && in_entry && !sw_hi; // [R9]
    sw_wr_hi  = bus_req.wr && in_entry && sw_hi; // [R9]
  end

  hrs_entry_file #(
    .DEPTH (DEPTH),
    .PC_W  (PC_W)
  ) u_entries (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .core_wr   (do_push && push_fits), // [R13]
    .core_idx  (push_idx),
    .core_data (core_req.pc),
    .sw_wr_lo  (sw_wr_lo),
    .sw_wr_hi  (sw_wr_hi),
    .sw_idx    (sw_idx),
    .sw_data   (bus_req.wdata),
    .rd_idx_a  (pop_idx),
    .rd_data_a (pop_data),
    .rd_idx_b  (sw_idx),
    .rd_data_b (sw_rd_data)
  );

  // Pointer and interrupt enable
  always_comb
  begin
    ptr_d    = ptr_q;
    irq_en_d = irq_en_q;
    if (bus_req.wr && bus_req.addr == `HRS_ADDR_PTR)
    begin
      ptr_d    = bus_req.wdata[`HRS_PTR_W-1:0]; // [R10] [R12]
      irq_en_d = bus_req.wdata[`HRS_IRQ_EN_BIT]; // [R11]
    end
    if (do_push)
      ptr_d = push_ptr; // [R3] [R13]
    else if (do_pop)
      ptr_d = ptr_q + `HRS_PTR_STEP; // [R3] [R8]
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ptr_q <= `HRS_PTR_EMPTY; // [R11]
      irq_en_q <= `HRS_IRQ_EN_RESET; // [R11]
    end
    else
    begin
      ptr_q    <= ptr_d;
      irq_en_q <= irq_en_d;
    end
  end

  // Popped address towards the program counter
  always_comb
  begin
    pop_d.valid = do_pop; // [R7]
    pop_d.kind  = core_req.pop_kind; // [R7]
    pop_d.pc    = pop_fits ? pop_data : '0; // [R5] [R8]
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pop_q <= '0;
    else
      pop_q <= pop_d;
  end

  // Sticky events, set wins over clear
  always_comb
  begin
    event_set                = '0;
    event_set[`HRS_EV_PUSH]  = do_push;
    event_set[`HRS_EV_POP]   = do_pop;
    event_set[`HRS_EV_OVER]  = do_push && !push_fits; // [R13]
    event_set[`HRS_EV_UNDER] = do_pop && !pop_fits;
    event_clr = '0;
    if (bus_req.wr && bus_req.addr == `HRS_ADDR_CLEAR)
      event_clr = bus_req.wdata[`HRS_EV_W-1:0];
    status_d = (status_q & ~event_clr) | event_set;
    enable_d = enable_q;
    if (bus_req.wr && bus_req.addr == `HRS_ADDR_ENABLE)
      enable_d = bus_req.wdata[`HRS_EV_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      status_q <= `HRS_EV_RESET;
      enable_q <= `HRS_EV_RESET;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
    end
  end

  // Read data, one cycle after the read strobe
  always_comb
  begin
    sw_rd_byte = sw_hi ?
      `HRS_BYTE_W'(sw_rd_data[PC_W-1:`HRS_BYTE_W]) :
      sw_rd_data[`HRS_BYTE_W-1:0]; // [R9]
    rdata_d = '0;
    if (bus_req.rd)
    begin
      if (bus_req.addr == `HRS_ADDR_PTR)
      begin
        rdata_d[`HRS_PTR_W-1:0] = ptr_q; // [R1] [R10]
        rdata_d[`HRS_IRQ_EN_BIT] = irq_en_q; // [R11]
      end
      else if (in_entry)
        rdata_d = sw_rd_byte; // [R10]
      else if (bus_req.addr == `HRS_ADDR_STATUS)
        rdata_d[`HRS_EV_W-1:0] = status_q;
      else if (bus_req.addr == `HRS_ADDR_ENABLE)
        rdata_d[`HRS_EV_W-1:0] = enable_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  assign bus_rdata         = rdata_q;
  assign pop_rsp           = pop_q;
  assign global_irq_enable = irq_en_q;
  assign irq               = |(status_q & enable_q);

endmodule

/* File: hrs_return_stack_assertions.sv */
`timescale 1ns/1ps
`include "hrs_regs.svh"
module hrs_return_stack_assertions
  import hrs_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire hrs_bus_req_type        bus_req,
  input wire logic [`HRS_BYTE_W-1:0] bus_rdata,
  input wire hrs_core_req_type       core_req,
  input wire hrs_pop_rsp_type        pop_rsp,
  input wire logic                   global_irq_enable,
  input wire logic                   irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence s_pop;
    core_req.pop && !core_req.push;
  endsequence
  sequence s_ptr_wr;
    bus_req.wr && bus_req.addr == 8'hdf;
  endsequence
  property p_pop_rsp;
    s_pop |=> pop_rsp.valid && pop_rsp.kind == $past(core_req.pop_kind);
  endproperty
  property p_no_rsp;
    !core_req.pop || core_req.push |=> !pop_rsp.valid;
  endproperty
  property p_rd_idle;
    !bus_req.rd |=> bus_rdata == 8'h00;
  endproperty
  property p_irq_en_wr;
    s_ptr_wr |=> global_irq_enable == $past(bus_req.wdata[7]);
  endproperty
  property p_irq_en_keep;
    !(bus_req.wr && bus_req.addr == 8'hdf) |=> $stable(global_irq_enable);
  endproperty
  property p_ptr_rd;
    bus_req.rd && bus_req.addr == 8'hdf
      |=> bus_rdata[7] == global_irq_enable && bus_rdata[6:3] == 4'h0;
  endproperty
  property p_hi_rd;
    bus_req.rd && bus_req.addr[7:4] == 4'hf && bus_req.addr[0]
      |=> bus_rdata[7:2] == 6'h00;
  endproperty
  property p_mask;
    bus_req.wr && bus_req.addr == 8'he2 && bus_req.wdata == 8'h00 |=> !irq;
  endproperty
  a_pop_rsp: assert property (p_pop_rsp)
    else $error("pop answer missing or wrong kind");
  a_no_rsp: assert property (p_no_rsp)
    else $error("pop answer without pop");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_irq_en_wr: assert property (p_irq_en_wr)
    else $error("interrupt enable not written");
  a_irq_en_keep: assert property (p_irq_en_keep)
    else $error("interrupt enable changed alone");
  a_ptr_rd: assert property (p_ptr_rd)
    else $error("pointer register read wrong");
  a_hi_rd: assert property (p_hi_rd)
    else $error("entry high byte upper bits set");
  a_mask: assert property (p_mask)
    else $error("interrupt not masked");
endmodule
bind hrs_return_stack hrs_return_stack_assertions u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .core_req(core_req), .pop_rsp(pop_rsp),
  .global_irq_enable(global_irq_enable), .irq(irq));

/* File: hrs_core_model.sv */
`timescale 1ns/1ps
module hrs_core_model
  import hrs_pkg::*;
(
  input  wire logic       mclk,
  output hrs_core_req_type core_req,
  input  wire hrs_pop_rsp_type pop_rsp
);
  initial core_req = '0;
  // Call or interrupt entry, after some idle cycles
  task automatic push(input logic [9:0] pc, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    core_req <= '{1'b1, 1'b0, HRS_RETURN_CALL, pc};
    @(posedge mclk);
    core_req <= '0;
  endtask
  // Either return kind, answer taken the cycle after
  task automatic pop(input hrs_return_kind_type k, output hrs_pop_rsp_type r);
    @(posedge mclk);
    core_req <= '{1'b0, 1'b1, k, 10'h000};
    @(posedge mclk);
    core_req <= '0;
    #1 r = pop_rsp;
  endtask
endmodule

/* File: hrs_return_stack_tb.sv */
`timescale 1ns/1ps
module hrs_return_stack_tb
  import hrs_pkg::*;
;
  logic             mclk;
  logic             sys_rst;
  hrs_bus_req_type  bus_req;
  hrs_core_req_type core_req;
  hrs_pop_rsp_type  pop_rsp;
  logic [7:0]       bus_rdata;
  logic             global_irq_enable;
  logic             irq;
  int               n_mismatch = 0;
  int               checked = 0;
  logic [9:0]       pcs [4] = '{10'h3a5, 10'h0c3, 10'h2f0, 10'h155};
  hrs_return_stack u_dut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .core_req(core_req), .pop_rsp(pop_rsp),
    .global_irq_enable(global_irq_enable), .irq(irq));
  hrs_core_model u_core (.mclk(mclk), .core_req(core_req), .pop_rsp(pop_rsp));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus_req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    bus_req <= '0;
    #1 chk({8'h00, bus_rdata}, {8'h00, e});
  endtask
  task automatic irq_chk(input logic e);
    #1 chk({15'h0, irq}, {15'h0, e});
  endtask
  task automatic pop_chk(input hrs_return_kind_type k, input logic [9:0] e);
    hrs_pop_rsp_type r;
    u_core.pop(k, r);
    chk({4'h0, r.valid, r.kind, r.pc}, {4'h0, 1'b1, k, e});
  endtask
  task automatic t_reset;
    rd_chk(8'hdf, 8'h07);
    for (int i = 0; i < 8; i++)
      rd_chk(8'hf0 + i[7:0], 8'h00);
    rd_chk(8'he3, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_ptr_reg;
    wr_reg(8'hdf, 8'h87);
    rd_chk(8'hdf, 8'h87);
    chk({15'h0, global_irq_enable}, 16'h0001);
    wr_reg(8'hdf, 8'h07);
    rd_chk(8'hdf, 8'h07);
    $display("pointer register test done");
  endtask
  task automatic t_lifo;
    for (int i = 0; i < 4; i++) u_core.push(pcs[i], i);
    rd_chk(8'hdf, 8'h03);
    rd_chk(8'hf6, pcs[3][7:0]);
    rd_chk(8'hf7, {6'h0, pcs[3][9:8]});
    u_core.push(10'h3ff, 0);
    rd_chk(8'hdf, 8'h02);
    rd_chk(8'hf6, pcs[3][7:0]);
    pop_chk(HRS_RETURN_CALL, 10'h000);
    for (int i = 3; i >= 0; i--)
      pop_chk(hrs_return_kind_type'(i[0]), pcs[i]);
    rd_chk(8'hdf, 8'h07);
    $display("stack order test done");
  endtask
  task automatic t_sw_entry;
    u_core.push(10'h111, 0);
    wr_reg(8'hf0, 8'h5a);
    wr_reg(8'hf1, 8'hff);
    rd_chk(8'hf1, 8'h03);
    pop_chk(HRS_RETURN_IRQ, 10'h35a);
    $display("entry write test done");
  endtask
  task automatic t_irq;
    wr_reg(8'he1, 8'h0f);
    wr_reg(8'he2, 8'h01);
    irq_chk(1'b0);
    u_core.push(10'h200, 0);
    irq_chk(1'b1);
    rd_chk(8'he0, 8'h01);
    wr_reg(8'he2, 8'h00);
    irq_chk(1'b0);
    wr_reg(8'he2, 8'h01);
    irq_chk(1'b1);
    wr_reg(8'he1, 8'h01);
    irq_chk(1'b0);
    rd_chk(8'he0, 8'h00);
    pop_chk(HRS_RETURN_IRQ, 10'h200);
    $display("interrupt test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    sys_rst = 1'b1;
    bus_req = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_ptr_reg;
    t_lifo;
    t_sw_entry;
    t_irq;
    report_and_stop;
  end
endmodule
